// ### logic/rcd_diag_error_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "rcd_regs_map.vh"
module rcd_diag_error_regs #(
  parameter GROUPS = 64 // number of selectable probe groups
) (
  input wire clock, // core clock, 100 MHz
  input wire rst_b, // async reset, active low
  input wire [31:0] regAddr, // register byte address
  input wire [31:0] regWdata, // write data
  input wire regWr, // write strobe
  input wire regRd, // read strobe
  output reg [31:0] regRdata, // read data, cycle after strobe
  input wire [GROUPS*8-1:0] probeGroups, // internal signal groups, same clock
  input wire [11:0] errEvents, // error event pulses, same clock
  output reg [7:0] probe_out_0, // diagnostic port 0
  output reg [7:0] probe_out_1, // diagnostic port 1
  output reg [7:0] probe_out_2, // diagnostic port 2
  output reg [7:0] probe_out_3, // diagnostic port 3
  output reg [`RCD_FINE_W-1:0] finePhaseOut, // fine correction to counter
  output reg [`RCD_BASE_W-1:0] baseTimeOut, // base correction to counter
  output reg sleepCorrApply // one-cycle pulse: load fixes, restart counters
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [`RCD_FINE_W-1:0] finePhaseFix_q; // fine phase correction
  reg [`RCD_BASE_W-1:0] baseTimeFix_q; // base time correction
  reg [31:0] probeCtrl_q; // probe enables and selectors
  reg [`RCD_ZONE_W-1:0] zoneUpper_q; // debug zone upper limit
  reg [`RCD_ZONE_W-1:0] zoneLower_q; // debug zone lower limit
  reg [`RCD_ERR_W-1:0] errFlags_q; // sticky error flags
  reg [`RCD_ERR_W-1:0] errFlags_d; // next error flags
  reg [31:0] rdata_d; // next read data
  wire [31:0] probeLive; // live probe port values

  // picks a byte group for one port, zero when disabled
  function [7:0] probeMux;
    input en;
    input [`RCD_SEL_W-1:0] sel;
    input [GROUPS*8-1:0] groups;
    begin
      if (en) begin
        probeMux = groups[sel*8 +: 8];
      end else begin
        probeMux = 8'h00;
      end
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // write decode for writable registers
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      finePhaseFix_q <= `RCD_RST_FINE;
      baseTimeFix_q <= `RCD_RST_BASE;
      probeCtrl_q <= `RCD_RST_CTRL;
      zoneUpper_q <= `RCD_RST_ZONE;
      zoneLower_q <= `RCD_RST_ZONE;
      sleepCorrApply <= 1'b0;
    end else begin
      sleepCorrApply <= 1'b0;
      if (regWr) begin
        case (regAddr)
          `RCD_ADDR_FINE_FIX: finePhaseFix_q <= regWdata[`RCD_FINE_W-1:0];
          `RCD_ADDR_BASE_FIX: baseTimeFix_q <= regWdata[`RCD_BASE_W-1:0];
          `RCD_ADDR_SLEEP_CTRL: sleepCorrApply <= regWdata[`RCD_SLEEP_CORR_BIT];
          `RCD_ADDR_PROBE_CTRL: probeCtrl_q <= regWdata & 32'hBFBF_BFBF;
          `RCD_ADDR_ZONE_UPPER: zoneUpper_q <= regWdata[`RCD_ZONE_W-1:0];
          `RCD_ADDR_ZONE_LOWER: zoneLower_q <= regWdata[`RCD_ZONE_W-1:0];
          default: begin
            // read-only or unmapped: ignored
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // correction outputs
  // ----------------------------------------
  // corrections handed to counters on apply
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      finePhaseOut <= `RCD_RST_FINE;
      baseTimeOut <= `RCD_RST_BASE;
    end else if (sleepCorrApply) begin
      finePhaseOut <= finePhaseFix_q;
      baseTimeOut <= baseTimeFix_q;
    end
  end

  // ----------------------------------------
  // probe ports
  // ----------------------------------------
  // registered probe outputs
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      probe_out_0 <= 8'h00;
      probe_out_1 <= 8'h00;
      probe_out_2 <= 8'h00;
      probe_out_3 <= 8'h00;
    end else begin
      probe_out_0 <= probeMux(probeCtrl_q[7], probeCtrl_q[5:0], probeGroups);
      probe_out_1 <= probeMux(probeCtrl_q[15], probeCtrl_q[13:8], probeGroups);
      probe_out_2 <= probeMux(probeCtrl_q[23], probeCtrl_q[21:16], probeGroups);
      probe_out_3 <= probeMux(probeCtrl_q[31], probeCtrl_q[29:24], probeGroups);
    end
  end

  // readback is the ports themselves
  assign probeLive = {probe_out_3, probe_out_2, probe_out_1, probe_out_0};

  // ----------------------------------------
  // error flags
  // ----------------------------------------
  // sticky set, bit 9 never set
  always @* begin
    errFlags_d = errFlags_q | (errEvents & `RCD_ERR_VALID_MASK);
  end

  // flag storage, cleared only by reset
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      errFlags_q <= `RCD_RST_ERR;
    end else begin
      errFlags_q <= errFlags_d;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // read mux, unmapped reads zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (regAddr)
      `RCD_ADDR_FINE_FIX: rdata_d[`RCD_FINE_W-1:0] = finePhaseFix_q;
      `RCD_ADDR_BASE_FIX: rdata_d[`RCD_BASE_W-1:0] = baseTimeFix_q;
      `RCD_ADDR_PROBE_CTRL: rdata_d = probeCtrl_q;
      `RCD_ADDR_PROBE_READ: rdata_d = probeLive;
      `RCD_ADDR_ZONE_UPPER: rdata_d[`RCD_ZONE_W-1:0] = zoneUpper_q;
      `RCD_ADDR_ZONE_LOWER: rdata_d[`RCD_ZONE_W-1:0] = zoneLower_q;
      `RCD_ADDR_ERR_FLAGS: rdata_d[`RCD_ERR_W-1:0] = errFlags_q;
      default: rdata_d = 32'h0000_0000; // sleep control reads zero too
    endcase
  end

  // read data register, held otherwise zero
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= rdata_d;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule // rcd_diag_error_regs
`default_nettype wire

// ### logic/rcd_regs_map.vh
`ifndef RCD_REGS_MAP_VH
`define RCD_REGS_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define RCD_ADDR_FINE_FIX 32'h4000_0040
`define RCD_ADDR_BASE_FIX 32'h4000_0044
`define RCD_ADDR_SLEEP_CTRL 32'h4000_0048
`define RCD_ADDR_PROBE_CTRL 32'h4000_0050
`define RCD_ADDR_PROBE_READ 32'h4000_0054
`define RCD_ADDR_ZONE_UPPER 32'h4000_0058
`define RCD_ADDR_ZONE_LOWER 32'h4000_005C
`define RCD_ADDR_ERR_FLAGS 32'h4000_0060
// ----------------------------------------
// field widths, positions and resets
// ----------------------------------------
`define RCD_FINE_W 10
`define RCD_BASE_W 27
`define RCD_ZONE_W 16
`define RCD_SEL_W 6
`define RCD_PROBE_W 8
`define RCD_ERR_W 12
`define RCD_SLEEP_CORR_BIT 3
`define RCD_PROBE_EN_OFS 7
`define RCD_ERR_VALID_MASK 12'hD_FF
`define RCD_RST_FINE 10'h000
`define RCD_RST_BASE 27'h000_0000
`define RCD_RST_CTRL 32'h0000_0000
`define RCD_RST_ZONE 16'h0000
`define RCD_RST_ERR 12'h000
`endif

// ### test/rcd_diag_error_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rcd_diag_asserts (
  input wire logic clock, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [31:0] regAddr, // bus address
  input wire logic [31:0] regWdata, // bus write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [31:0] regRdata, // read data
  input wire logic [7:0] probe_out_0, // probe port 0
  input wire logic sleepCorrApply // correction pulse
);
  // strobe flag above the low address byte, block page only
  wire [8:0] rA = {regRd && regAddr[31:8] == 24'h40_0000, regAddr[7:0]};
  wire [8:0] wA = {regWr && regAddr[31:8] == 24'h40_0000, regAddr[7:0]};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_fine_rd: assert property (rA == 9'h140 |=> regRdata[31:10] == 0)
    else $error("fine fix high bits set");
  chk_base_rd: assert property (rA == 9'h144 |=> regRdata[31:27] == 0)
    else $error("base fix high bits set");
  chk_zone_rd: assert property (rA == 9'h158 || rA == 9'h15C |=> regRdata[31:16] == 0)
    else $error("zone limit high bits set");
  chk_err_gaps: assert property (rA == 9'h160 |=> regRdata[31:12] == 0 && !regRdata[9])
    else $error("error flag gap bits set");
  chk_stat_live: assert property (rA == 9'h154 |=> regRdata[7:0] == $past(probe_out_0))
    else $error("readback differs from port");
  chk_probe_off: assert property (wA == 9'h150 && !regWdata[7] ##1 !regWr |=> probe_out_0 == 0)
    else $error("disabled port not zero");
  chk_sleep_go: assert property (wA == 9'h148 && regWdata[3] |=> sleepCorrApply)
    else $error("no correction pulse");
  chk_sleep_rd: assert property (rA == 9'h148 |=> regRdata == 0)
    else $error("sleep control reads nonzero");
  cover property (sleepCorrApply);
  cover property (rA == 9'h154);
  cover property (rA == 9'h160 ##1 regRdata[4]);
endmodule // rcd_diag_asserts
bind rcd_diag_error_regs rcd_diag_asserts u_chk (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .probe_out_0(probe_out_0), .sleepCorrApply(sleepCorrApply));
`default_nettype wire

// ### test/tb_rcd_diag_error_regs.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_rcd_diag_error_regs;
  logic clock = 0, rst_b = 0, regWr = 0, regRd = 0; // clock, reset, strobes
  logic [31:0] regAddr = 0, regWdata = 0; // bus request
  wire [31:0] regRdata; // bus answer
  logic [511:0] probeGroups = 0; // probe signal groups
  logic [11:0] errEvents = 0, errM = 0; // event pulses, model flags
  wire [7:0] p0, p1, p2, p3; // probe ports
  wire [9:0] fineOut; // fine correction handoff
  wire [26:0] baseOut; // base correction handoff
  wire sc; // correction apply pulse
  logic [36:0] corrM = 0; // model of applied corrections
  logic [31:0] mdl [256] = '{default: 0}; // model of stored words
  logic [7:0] adr [9] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60};
  int err_total = 0, n_checks = 0, cyc = 0;
  rcd_diag_error_regs u_rcd_diag_error_regs (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .probeGroups(probeGroups), .errEvents(errEvents), .probe_out_0(p0), .probe_out_1(p1),
    .probe_out_2(p2), .probe_out_3(p3), .finePhaseOut(fineOut), .baseTimeOut(baseOut),
    .sleepCorrApply(sc));
  // writable bits of each word
  function automatic logic [31:0] msk(logic [7:0] a);
    case (a)
      8'h40: msk = 32'h0000_03FF;
      8'h44: msk = 32'h07FF_FFFF;
      8'h50: msk = 32'hBFBF_BFBF;
      8'h58, 8'h5C: msk = 32'h0000_FFFF;
      default: msk = 32'h0000_0000;
    endcase
  endfunction
  // expected port value from stored control
  function automatic logic [7:0] pe(int k);
    logic [31:0] c;
    c = mdl[8'h50];
    pe = c[8*k+7] ? probeGroups[8*c[8*k+:6]+:8] : 8'h00;
  endfunction
  function automatic logic [31:0] rexp(logic [7:0] a);
    rexp = (a == 8'h54) ? {pe(3), pe(2), pe(1), pe(0)} : (a == 8'h60) ? {20'h0_0000, errM} : mdl[a];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr <= 1;
    regAddr <= {24'h40_0000, a};
    regWdata <= d;
    @(posedge clock);
    regWr <= 0;
    mdl[a] = d & msk(a);
    if (a == 8'h48 && d[3]) corrM = {mdl[8'h44][26:0], mdl[8'h40][9:0]};
  endtask
  task automatic rdc(input logic [7:0] a);
    @(posedge clock);
    regRd <= 1;
    regAddr <= {24'h40_0000, a};
    @(posedge clock);
    regRd <= 0;
    #1 `CHK(regRdata, rexp(a))
  endtask
  task done(int t);
    $display("test %0d finished", t);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(90));
    repeat (10) @(posedge clock);
    rst_b <= 1;
    foreach (adr[i]) rdc(adr[i]);
    done(1);
    foreach (adr[i]) begin
      wr(adr[i], $urandom);
      rdc(adr[i]);
    end
    done(2);
    for (int g = 0; g < 16; g++) probeGroups[32*g+:32] <= $urandom;
    repeat (8) begin
      wr(8'h50, $urandom);
      repeat (2) @(posedge clock);
      #1 `CHK({p3, p2, p1, p0}, rexp(8'h54))
      rdc(8'h54);
    end
    done(3);
    wr(8'h48, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1 `CHK({baseOut, fineOut}, corrM)
    wr(8'h48, 32'h0000_0008);
    #1 `CHK(sc, 1'b1)
    repeat (2) @(posedge clock);
    #1 `CHK({baseOut, fineOut}, corrM)
    done(4);
    for (int n = 0; n < 12; n++) begin
      @(posedge clock);
      errEvents <= 12'h001 << n;
      @(posedge clock);
      errEvents <= 0;
      errM = errM | ((12'h001 << n) & 12'hDFF);
      rdc(8'h60);
    end
    @(posedge clock);
    rst_b <= 0;
    @(posedge clock);
    rst_b <= 1;
    errM = 0;
    corrM = 0;
    mdl = '{default: 0};
    rdc(8'h60);
    rdc(8'h50);
    done(5);
    report_and_stop;
  end
endmodule // tb_rcd_diag_error_regs
`default_nettype wire
